// File: svsp_pkg.sv
package svsp_pkg;
    localparam int WORD_W      = 16;              // Serial word width
    localparam int CODE_W      = 8;               // One channel level code
    localparam int REF_CLK_HZ  = 40_000_000;      // System clock rate
    localparam int POR_TIME_US = 100;             // Power-on reset settle time
    // Cycles of settle time, rounded down
    localparam int POR_CYCLES  = (POR_TIME_US * (REF_CLK_HZ / 1_000_000));
    localparam int CAL_CYCLES  = 64;              // Offset calibration length
    localparam int CNT_W       = 13;              // Sequencer counter width
    localparam logic [CODE_W-1:0] CODE_UNITY = 8'hc0; // Unity gain code
    localparam logic [CODE_W-1:0] CODE_SMUTE = 8'h00; // Software mute code
    localparam logic [WORD_W-1:0] WORD_CLEAR = 16'h0000; // Cleared value

    // Power-up sequencer states
    typedef enum logic [1:0] {
        SVSP_POR,
        SVSP_CAL,
        SVSP_RUN,
        SVSP_LOW
    } svsp_state_t;
endpackage : svsp_pkg

// File: svsp_sync.sv
// Two-flop level synchroniser
module svsp_sync
    import svsp_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    // State: first and second stage
    typedef struct packed {
        logic s1_r;
        logic s2_r;
    } svsp_sync_t;
    svsp_sync_t st_r;
    svsp_sync_t st_nxt;

    // Next state: first stage feeds only the second
    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1_r = d_i;
        st_nxt.s2_r = st_r.s1_r;
    end

    // Register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '{s1_r: RST_VAL, s2_r: RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.s2_r;
endmodule // svsp_sync

// File: svsp_shift.sv
// Link-side shift register, runs on the shift clock
module svsp_shift
    import svsp_pkg::*;
#(
    parameter int W = WORD_W
) (
    input  wire logic         sclk_i,
    input  wire logic         clr_n_i,    // Async clear from core (power-up)
    input  wire logic         sel_n_i,
    input  wire logic         serial_in_i,
    output logic [W-1:0]      shift_o,
    output logic              serial_out_o,
    output logic              serial_oe_o
);
    // State of the link side
    typedef struct packed {
        logic [W-1:0] sh_r;   // Shift register
        logic         so_r;   // Output bit, falling edge
    } svsp_shift_t;
    logic [W-1:0] sh_r;
    logic [W-1:0] sh_nxt;
    logic         so_r;

    // MSB first; shift in on rising edge while selected
    always_comb begin
        sh_nxt = sh_r;
        if (!sel_n_i) begin
            sh_nxt = {sh_r[W-2:0], serial_in_i};
        end
    end

    // Rising-edge capture; cleared by power-up sequence
    always_ff @(posedge sclk_i or negedge clr_n_i) begin
        if (!clr_n_i) begin
            sh_r <= WORD_CLEAR;
        end else begin
            sh_r <= sh_nxt;
        end
    end

    // Output bit follows the MSB, updated on the falling edge
    always_ff @(negedge sclk_i or negedge clr_n_i) begin
        if (!clr_n_i) begin
            so_r <= 1'b0;
        end else begin
            so_r <= sh_r[W-1];
        end
    end

    assign shift_o      = sh_r;
    assign serial_out_o = so_r;
    assign serial_oe_o  = ~sel_n_i;
endmodule // svsp_shift

// File: svsp_top.sv
// Serial control port of a two-channel volume control
module svsp_top
    import svsp_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES,  // Power-on settle, in clocks
    parameter int CAL_CNT = CAL_CYCLES   // Calibration length, in clocks
) (
    input  wire logic              REF_CLK_I,     // System clock
    input  wire logic              RESET_N_I,     // Power-on reset, active low
    input  wire logic              SCLK_I,        // Shift clock from host
    input  wire logic              SEL_N_I,       // Select, active low
    input  wire logic              SERIAL_IN_I,   // Serial data in
    input  wire logic              MUTE_N_I,      // Hardware mute, active low
    input  wire logic              SUPPLY_LOW_I,  // Supply below threshold
    output logic                   SERIAL_OUT_O,  // Serial data out
    output logic                   SERIAL_OE_O,   // Serial out enable
    output logic [CODE_W-1:0]      RIGHT_CODE_O,  // Right level code
    output logic [CODE_W-1:0]      LEFT_CODE_O,   // Left level code
    output logic                   RIGHT_SMUTE_O, // Right at soft mute
    output logic                   LEFT_SMUTE_O,  // Left at soft mute
    output logic                   HW_MUTE_O,     // Hardware mute active
    output logic                   CAL_BUSY_O,    // Offset calibration running
    output logic                   READY_O        // Serial loads accepted
);
    // Reset release chain
    logic rst_s1_r;
    logic rst_n;
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // Synchronised pins
    logic sel_n_s;
    logic mute_n_s;
    logic low_s;
    svsp_sync #(.RST_VAL(1'b1)) u_sync_sel (
        .clk_i   (REF_CLK_I),
        .rst_n_i (rst_n),
        .d_i     (SEL_N_I),
        .q_o     (sel_n_s)
    );
    svsp_sync #(.RST_VAL(1'b0)) u_sync_mute (
        .clk_i   (REF_CLK_I),
        .rst_n_i (rst_n),
        .d_i     (MUTE_N_I),
        .q_o     (mute_n_s)
    );
    svsp_sync #(.RST_VAL(1'b1)) u_sync_low (
        .clk_i   (REF_CLK_I),
        .rst_n_i (rst_n),
        .d_i     (SUPPLY_LOW_I),
        .q_o     (low_s)
    );

    // Link-side shift register; cleared while sequencer clears
    logic [WORD_W-1:0] shift_w;
    logic              so_w;          // Shift-through bit, a flop on the shift clock fall
    logic              link_clr_n;
    svsp_shift #(.W(WORD_W)) u_shift (
        .sclk_i       (SCLK_I),
        .clr_n_i      (link_clr_n),
        .sel_n_i      (SEL_N_I),
        .serial_in_i  (SERIAL_IN_I),
        .shift_o      (shift_w),
        .serial_out_o (so_w),
        .serial_oe_o  ()              // Enable is rebuilt from the synchronised select
    );

    // Core state
    typedef struct packed {
        svsp_state_t       st;
        logic [CNT_W-1:0]  cnt;
        logic              sel_d;
        logic              mute_d;
        logic [WORD_W-1:0] vol;
        logic              clr_n;
        logic              oe_r;
        logic              smr;
        logic              sml;
        logic              hwm;
        logic              cal;
        logic              rdy;
    } svsp_core_t;
    svsp_core_t c_r;
    svsp_core_t c_nxt;

    // Sequencer and volume latch
    always_comb begin
        c_nxt        = c_r;
        c_nxt.sel_d  = sel_n_s;
        c_nxt.mute_d = mute_n_s;
        // Drive only once select is seen low through the synchroniser
        // and loads are accepted; the host allows a select setup time
        c_nxt.oe_r   = ~sel_n_s & c_r.rdy;
        case (c_r.st)
            SVSP_POR: begin
                // Settle without serial loads
                c_nxt.clr_n = 1'b0;
                c_nxt.vol   = WORD_CLEAR;
                if (c_r.cnt >= CNT_W'(POR_CNT - 1)) begin
                    c_nxt.cnt = '0;
                    c_nxt.st  = SVSP_CAL;
                end else begin
                    c_nxt.cnt = c_r.cnt + 1'b1;
                end
            end
            SVSP_CAL: begin
                // Calibrate on the system clock only
                c_nxt.clr_n = 1'b1;
                if (c_r.cnt >= CNT_W'(CAL_CNT - 1)) begin
                    c_nxt.cnt = '0;
                    c_nxt.st  = SVSP_RUN;
                end else begin
                    c_nxt.cnt = c_r.cnt + 1'b1;
                end
            end
            SVSP_RUN: begin
                // Select rising edge latches word
                if (sel_n_s && !c_r.sel_d) begin
                    c_nxt.vol = shift_w;
                end
                // Mute fall restarts power-up
                if (!mute_n_s && c_r.mute_d) begin
                    c_nxt.st = SVSP_POR;
                end
            end
            SVSP_LOW: begin
                // Hold cleared and muted until supply recovers
                c_nxt.clr_n = 1'b0;
                c_nxt.vol   = WORD_CLEAR;
                if (!low_s) begin
                    c_nxt.cnt = '0;
                    c_nxt.st  = SVSP_POR;
                end
            end
            default: begin
                c_nxt.st = SVSP_POR;
            end
        endcase
        if (low_s) begin
            c_nxt.st  = SVSP_LOW;
            c_nxt.cnt = '0;
        end
        if (c_nxt.st == SVSP_POR && c_r.st != SVSP_POR) begin
            c_nxt.cnt = '0;
        end
        // First byte shifted in lands in the upper half
        c_nxt.smr = (c_nxt.vol[WORD_W-1 -: CODE_W] == CODE_SMUTE);
        c_nxt.sml = (c_nxt.vol[CODE_W-1:0] == CODE_SMUTE);
        c_nxt.hwm = (c_nxt.st != SVSP_RUN) || !mute_n_s;
        c_nxt.cal = (c_nxt.st == SVSP_CAL);
        c_nxt.rdy = (c_nxt.st == SVSP_RUN);
    end

    // Register core state
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            c_r <= '{st: SVSP_POR, cnt: '0, sel_d: 1'b1, mute_d: 1'b0,
                     vol: WORD_CLEAR, clr_n: 1'b0, oe_r: 1'b0,
                     smr: 1'b1, sml: 1'b1, hwm: 1'b1, cal: 1'b0, rdy: 1'b0};
        end else begin
            c_r <= c_nxt;
        end
    end

    assign link_clr_n    = c_r.clr_n;
    // Straight from the link flop, so a chained device sees each fall in time
    assign SERIAL_OUT_O  = so_w;
    assign SERIAL_OE_O   = c_r.oe_r;
    assign RIGHT_CODE_O  = c_r.vol[WORD_W-1 -: CODE_W];
    assign LEFT_CODE_O   = c_r.vol[CODE_W-1:0];
    assign RIGHT_SMUTE_O = c_r.smr;
    assign LEFT_SMUTE_O  = c_r.sml;
    assign HW_MUTE_O     = c_r.hwm;
    assign CAL_BUSY_O    = c_r.cal;
    assign READY_O       = c_r.rdy;
endmodule // svsp_top

// File: svsp_monitor.sv
// Protocol checker for the serial control port, bound to the top module
module svsp_monitor
    import svsp_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES,
    parameter int CAL_CNT = CAL_CYCLES
) (
    input wire logic              REF_CLK_I,
    input wire logic              RESET_N_I,
    input wire logic              SEL_N_I,
    input wire logic              SUPPLY_LOW_I,
    input wire logic              SERIAL_OE_O,
    input wire logic [CODE_W-1:0] RIGHT_CODE_O,
    input wire logic [CODE_W-1:0] LEFT_CODE_O,
    input wire logic              RIGHT_SMUTE_O,
    input wire logic              LEFT_SMUTE_O,
    input wire logic              HW_MUTE_O,
    input wire logic              CAL_BUSY_O,
    input wire logic              READY_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cal_len_r; // Clocks spent in the current calibration
    // Count calibration length so an endless one is caught
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cal_len_r <= 16'h0000;
        end else begin
            cal_len_r <= CAL_BUSY_O ? cal_len_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    a_oe_off_idle: assert property (SEL_N_I [*5] |-> !SERIAL_OE_O)
        else $error("serial out driven while deselected");
    a_oe_off_early: assert property (!READY_O [*3] |-> !SERIAL_OE_O)
        else $error("serial out driven before ready");
    a_clear_not_run: assert property (!READY_O [*3] |->
        {LEFT_CODE_O, RIGHT_CODE_O} == WORD_CLEAR)
        else $error("codes not cleared outside run");
    a_smute_follows: assert property ($stable(RIGHT_CODE_O) && $stable(LEFT_CODE_O) |->
        RIGHT_SMUTE_O == (RIGHT_CODE_O == CODE_SMUTE)
        && LEFT_SMUTE_O == (LEFT_CODE_O == CODE_SMUTE))
        else $error("soft mute flag disagrees with code");
    a_mute_not_run: assert property (!READY_O |-> HW_MUTE_O)
        else $error("hardware mute off outside run");
    a_supply_mutes: assert property (SUPPLY_LOW_I [*6] |-> HW_MUTE_O && !READY_O)
        else $error("supply low did not mute");
    a_latch_on_sel: assert property ((RIGHT_CODE_O != $past(RIGHT_CODE_O)
        || LEFT_CODE_O != $past(LEFT_CODE_O)) && READY_O && $past(READY_O)
        |-> SEL_N_I && $past(SEL_N_I, 3) && !$past(SEL_N_I, 7))
        else $error("codes changed without a select rise");
    a_cal_bounded: assert property (cal_len_r <= 16'(CAL_CNT + 2))
        else $error("calibration overran");
    a_ready_after_cal: assert property ($rose(READY_O) |->
        $past(CAL_BUSY_O) || $past(CAL_BUSY_O, 2))
        else $error("ready without calibration");
endmodule // svsp_monitor

bind svsp_top svsp_monitor #(.POR_CNT(POR_CNT), .CAL_CNT(CAL_CNT)) svsp_monitor_i (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .SEL_N_I(SEL_N_I),
    .SUPPLY_LOW_I(SUPPLY_LOW_I), .SERIAL_OE_O(SERIAL_OE_O), .RIGHT_CODE_O(RIGHT_CODE_O),
    .LEFT_CODE_O(LEFT_CODE_O), .RIGHT_SMUTE_O(RIGHT_SMUTE_O), .LEFT_SMUTE_O(LEFT_SMUTE_O),
    .HW_MUTE_O(HW_MUTE_O), .CAL_BUSY_O(CAL_BUSY_O), .READY_O(READY_O));

// File: svsp_host.sv
// Host side of the three-wire port; shift clock runs only within frames
module svsp_host
    import svsp_pkg::*;
(
    input  wire logic serial_out_i, // Shift-through line from the device
    output logic      sclk_o,
    output logic      sel_n_o,
    output logic      serial_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] rb; // Bits seen on the shift-through line
    localparam int SEL_SETUP = 150; // Select low before first clock, covers enable resync
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        serial_in_o = 1'b0;
        rb = WORD_CLEAR;
    end
    // One whole word, MSB first, data changed on the falling edge
    task automatic send(input logic [WORD_W-1:0] w, input int half);
        sel_n_o = 1'b0;
        #(SEL_SETUP);
        for (int i = WORD_W - 1; i >= 0; i--) begin
            serial_in_o = w[i];
            #(half);
            rb = {rb[WORD_W-2:0], serial_out_i};
            sclk_o = 1'b1;
            #(half);
            sclk_o = 1'b0;
        end
        #(half);
        sel_n_o = 1'b1;
        serial_in_o = ~serial_in_o; // Released line keeps no stale bit
    endtask
endmodule // svsp_host

// File: test_stereo_volume_serial_port.sv
// Bench for the serial control port
module test_stereo_volume_serial_port import svsp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, reset_n = 1'b0, mute_n = 1'b0, supply_low = 1'b0;
    logic sclk, sel_n, sdi, sdo_bit, sdo_oe, hw_mute, cal_busy, ready, r_sm, l_sm;
    logic [CODE_W-1:0] r_code, l_code;
    wire sdo = sdo_oe ? sdo_bit : 1'bz; // Line as the next device sees it
    int failures = 0, tests_run = 0, seed = 93358;
    logic [WORD_W-1:0] prev; // Word the shift register now holds
    logic [32:0] notes[$]; // Readback flag, expected codes, expected readback
    svsp_top #(.POR_CNT(60), .CAL_CNT(8)) svsp_top_i (
        .REF_CLK_I(ref_clk), .RESET_N_I(reset_n), .SCLK_I(sclk), .SEL_N_I(sel_n),
        .SERIAL_IN_I(sdi), .MUTE_N_I(mute_n), .SUPPLY_LOW_I(supply_low),
        .SERIAL_OUT_O(sdo_bit), .SERIAL_OE_O(sdo_oe), .RIGHT_CODE_O(r_code),
        .LEFT_CODE_O(l_code), .RIGHT_SMUTE_O(r_sm), .LEFT_SMUTE_O(l_sm),
        .HW_MUTE_O(hw_mute), .CAL_BUSY_O(cal_busy), .READY_O(ready));
    svsp_host svsp_host_i (.serial_out_i(sdo), .sclk_o(sclk), .sel_n_o(sel_n),
        .serial_in_o(sdi));
    task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait for the sequencer to accept loads
    task automatic wait_ready();
        int k;
        for (k = 0; k < 300 && ready !== 1'b1; k++) @(posedge ref_clk);
        if (k == 300) begin
            failures++;
            conclude();
        end
    endtask
    // Note the expected outcome, then send on the 48 ns link clock
    task automatic frame(input logic [WORD_W-1:0] w, input bit live);
        notes.push_back({live, live ? w : WORD_CLEAR, prev});
        svsp_host_i.send(w, 24);
        if (live) prev = w;
        repeat (10) @(posedge ref_clk);
    endtask
    initial forever #12.5 ref_clk = ~ref_clk;
    // Watchdog
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        conclude();
    end
    // After each select rise, compare outputs with the oldest note
    initial begin
        logic [32:0] n;
        forever begin
            @(posedge sel_n);
            repeat (8) @(posedge ref_clk);
            if (notes.size() > 0) begin
                n = notes.pop_front();
                check("codes", {r_code, l_code}, n[31:16]);
                check("smute", {14'h0, r_sm, l_sm}, {14'h0, n[31:24] == CODE_SMUTE,
                    n[23:16] == CODE_SMUTE});
                if (n[32]) check("readback", svsp_host_i.rb, n[15:0]);
            end
        end
    end
    initial begin
        logic [WORD_W-1:0] w;
        prev = WORD_CLEAR;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        mute_n <= 1'b1;
        frame(16'h5a5a, 1'b0);
        wait_ready();
        check("ready codes", {r_code, l_code}, WORD_CLEAR);
        for (int i = 0; i < 8; i++) begin
            w = 16'($random(seed));
            if (i == 1) w = {CODE_SMUTE, CODE_UNITY};
            if (i == 2) w = {CODE_UNITY, CODE_SMUTE};
            frame(w, 1'b1);
        end
        mute_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        mute_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("mute codes", {r_code, l_code}, WORD_CLEAR);
        prev = WORD_CLEAR;
        wait_ready();
        frame(16'($random(seed)), 1'b1);
        supply_low <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check("low mute", {15'h0, hw_mute}, 16'h0001);
        frame(16'h1234, 1'b0);
        supply_low <= 1'b0;
        prev = WORD_CLEAR;
        wait_ready();
        frame(16'($random(seed)), 1'b1);
        repeat (20) @(posedge ref_clk);
        conclude();
    end
endmodule // test_stereo_volume_serial_port
